//--- aqscw_core.sv
// Two-queue converter sequencer: queue states, word pointers and command word table
//
// Overview of operation
// R1 - At most one queue active; either or both queues may be paused.
// R2 - A paused queue executes nothing until its own next trigger arrives.
// R3 - Queue 1 trigger aborts running queue 2, which shows suspended until queue 1 stops.
// R4 - Queue 2 trigger during active queue 1 goes pending; only queue 2 suspends or pends.
// R5 - Pending queue 2 stays pending a few cycles after queue 1 stops.
// R6 - Stop mode returns the queue status field to both queues idle.
// R7 - Debug freeze leaves the queue status field untouched.
// R8 - Current pointer is six bits, read only, writes ignored.
// R9 - On pause the current pointer holds the pausing word until any trigger.
// R10 - Current pointer may move to the new queue before its status shows active.
// R11 - Scan ending on end-of-queue channel leaves current pointer at that word.
// R12 - Queue ending past word 63 without end code leaves current pointer at zero.
// R13 - Queue 1 ending at queue 2 start word points there; queue 1 pointer keeps its last.
// R14 - Stop mode clears current pointer to zero; freeze leaves it alone.
// R15 - Per-queue pointer register is read only and stop resets it to 3f3f.
// R16 - Queue 1 pointer updates only when a queue 1 result is written; queue 2 results leave it.
// R17 - Stop mode sets queue 1 pointer to 63; freeze keeps it.
// R18 - Queue 2 pointer read only, updates on result, stop sets 63, freeze keeps.
// R19 - Pause flag set: convert word, then pause; next trigger resumes at next word.
// R20 - Pause flag ignored in software-controlled and gated modes.
// R21 - Sample time codes 0..3 give 2, 4, 8 or 16 conversion clocks.
// R22 - Channel 63 ends queue; channels 60 to 62 bypass the sampling amplifier.
`timescale 1ns/1ps
`default_nettype none
`include "aqscw_regs.svh"
module aqscw_core #(
  parameter logic [7:0] CONV_CLKS = `AQSCW_CONV_CLKS,
  parameter logic [2:0] PEND_CYCLES = `AQSCW_PEND_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Avalon-MM slave
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Trigger sources
  input wire logic trig_q1_in,
  input wire logic trig_q2_in,
  input wire logic timer_tick_in,
  // Low-power and debug
  input wire logic stop_in,
  input wire logic freeze_in,
  // Result record of each finished conversion, valid for one cycle
  output var aqscw_pkg::aqscw_result_t result_out
);
  aqscw_pkg::aqscw_state_t st_q;
  aqscw_pkg::aqscw_state_t st_d;
  aqscw_pkg::aqscw_ccw_t w;
  aqscw_pkg::aqscw_mode_t m1;
  aqscw_pkg::aqscw_mode_t m2;
  aqscw_pkg::aqscw_mode_t mode;
  logic [5:0] bq2;
  logic [5:0] nxt;
  logic [5:0] start;
  logic [7:0] total;
  logic [3:0] qs;
  logic rd_acc;
  logic wr_acc;
  logic sw1;
  logic sw2;
  logic t1;
  logic t2;
  logic abort2;
  logic end_of_queue_code;
  logic wrap;
  logic gate;

  function automatic logic [15:0] be_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] be);
    be_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic trig_event(input aqscw_pkg::aqscw_mode_t md, input logic src,
                                      input logic edge_v, input logic tick, input logic sw);
    case (md)
      aqscw_pkg::MODE_TRIG: trig_event = src ? tick : edge_v;
      aqscw_pkg::MODE_GATED: trig_event = edge_v;
      aqscw_pkg::MODE_SW: trig_event = sw;
      default: trig_event = 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] qs_code(input aqscw_pkg::aqscw_q1_t a,
                                         input aqscw_pkg::aqscw_q2_t b);
    logic [1:0] hi;
    logic [1:0] lo;
    hi = (a == aqscw_pkg::Q1_ACTIVE) ? 2'h2 : (a == aqscw_pkg::Q1_PAUSED) ? 2'h1 : 2'h0;
    case (b)
      aqscw_pkg::Q2_PAUSED: lo = 2'h1;
      aqscw_pkg::Q2_ACTIVE: lo = 2'h2;
      aqscw_pkg::Q2_SUSP: lo = 2'h2;
      aqscw_pkg::Q2_PEND: lo = 2'h3;
      default: lo = 2'h0;
    endcase
    qs_code = {hi, lo};
  endfunction

  assign qs = qs_code(st_q.q1st, st_q.q2st);
  assign m1 = aqscw_pkg::aqscw_mode_t'(st_q.ctrl[`AQSCW_CTRL_Q1MODE +: 2]);
  assign m2 = aqscw_pkg::aqscw_mode_t'(st_q.ctrl[`AQSCW_CTRL_Q2MODE +: 2]);
  assign bq2 = st_q.ctrl[`AQSCW_CTRL_BQ2 +: 6];
  assign w = st_q.words[st_q.cur_ptr];
  assign mode = st_q.cur_q ? m2 : m1;
  assign gate = st_q.cur_q ? trig_q2_in : trig_q1_in;
  assign start = st_q.cur_q ? bq2 : `AQSCW_Q1_START;
  assign wrap = st_q.cur_q ? st_q.q2_wrap : st_q.q1_wrap;
  assign nxt = st_q.cur_ptr + 6'h01;
  // Sample window doubles per code step, conversion part is fixed
  assign total = (`AQSCW_SAMPLE_BASE << st_q.word.sample_time_select) + CONV_CLKS; // R21
  assign rd_acc = avs_read_in && !st_q.waitreq;
  assign wr_acc = avs_write_in && !st_q.waitreq && !stop_in;
  assign sw1 = wr_acc && avs_address_in == `AQSCW_OFS_SWTRIG && avs_byteenable_in[0]
               && avs_writedata_in[`AQSCW_SWTRIG_Q1];
  assign sw2 = wr_acc && avs_address_in == `AQSCW_OFS_SWTRIG && avs_byteenable_in[0]
               && avs_writedata_in[`AQSCW_SWTRIG_Q2];
  assign t1 = trig_event(m1, st_q.ctrl[`AQSCW_CTRL_Q1SRC], trig_q1_in && !st_q.pin1,
                         timer_tick_in, sw1) && !freeze_in && !stop_in;
  assign t2 = trig_event(m2, st_q.ctrl[`AQSCW_CTRL_Q2SRC], trig_q2_in && !st_q.pin2,
                         timer_tick_in, sw2) && !freeze_in && !stop_in;
  assign abort2 = t1 && st_q.q1st != aqscw_pkg::Q1_ACTIVE && st_q.q2st == aqscw_pkg::Q2_ACTIVE;
  assign end_of_queue_code = w.channel_select == `AQSCW_EOQ_CODE || wrap
               || (!st_q.cur_q && st_q.cur_ptr == bq2);

  always_comb begin
    st_d = st_q;
    st_d.res.valid = 1'b0;
    st_d.conv_tick = 1'b0;
    st_d.pin1 = trig_q1_in;
    st_d.pin2 = trig_q2_in;
    // One wait state: data is ready when waitrequest drops
    if ((avs_read_in || avs_write_in) && st_q.waitreq) begin
      st_d.waitreq = 1'b0;
      st_d.rdata = 32'h0000_0000;
      if (avs_address_in[11:8] == `AQSCW_TBL_PAGE) begin
        st_d.rdata[15:0] = st_q.words[avs_address_in[7:2]];
      end else begin
        case (avs_address_in)
          `AQSCW_OFS_CTRL: st_d.rdata[15:0] = st_q.ctrl;
          `AQSCW_OFS_STAT: st_d.rdata[9:0] = {qs, st_q.current_word_pointer};
          `AQSCW_OFS_PTRS: st_d.rdata[15:0] = {2'h0, st_q.first_queue_pointer, 2'h0,
                                               st_q.second_queue_pointer}; // R15
          `AQSCW_OFS_PRESC: st_d.rdata[7:0] = st_q.presc;
          default: st_d.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      st_d.waitreq = 1'b1;
    end
    // Status and pointer words are absent from the write decode
    if (wr_acc) begin // R8
      if (avs_address_in[11:8] == `AQSCW_TBL_PAGE) begin
        st_d.words[avs_address_in[7:2]] = be_merge(st_q.words[avs_address_in[7:2]],
                                                   avs_writedata_in[15:0], avs_byteenable_in[1:0]);
      end else if (avs_address_in == `AQSCW_OFS_CTRL) begin
        st_d.ctrl = be_merge(st_q.ctrl, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
      end else if (avs_address_in == `AQSCW_OFS_PRESC && avs_byteenable_in[0]) begin
        st_d.presc = avs_writedata_in[7:0];
      end
    end
    // Freeze holds the whole sequencer, the bus keeps answering
    if (!freeze_in) begin // R7
      if (st_q.div_cnt == st_q.presc) begin
        st_d.div_cnt = 8'h00;
        st_d.conv_tick = 1'b1;
      end else begin
        st_d.div_cnt = st_q.div_cnt + 8'h01;
      end
      if (t1 && st_q.q1st != aqscw_pkg::Q1_ACTIVE) begin // R2
        st_d.q1st = aqscw_pkg::Q1_ACTIVE;
        if (abort2) begin // R3
          st_d.q2st = aqscw_pkg::Q2_SUSP;
          st_d.seq = aqscw_pkg::SEQ_IDLE;
        end
      end
      // Extra triggers while busy, suspended or pending are dropped
      if (t2 && (st_q.q2st == aqscw_pkg::Q2_IDLE || st_q.q2st == aqscw_pkg::Q2_PAUSED)) begin
        st_d.q2st = (st_d.q1st == aqscw_pkg::Q1_ACTIVE) ? aqscw_pkg::Q2_PEND
                                                         : aqscw_pkg::Q2_ACTIVE; // R4
        // A fresh scan starts at the queue 2 start word; a paused one resumes
        if (st_q.q2st == aqscw_pkg::Q2_IDLE) begin
          st_d.q2_next = bq2;
          st_d.q2_wrap = 1'b0;
        end
      end
      if (st_q.q2st == aqscw_pkg::Q2_PEND && st_d.q1st != aqscw_pkg::Q1_ACTIVE) begin
        if (st_q.pend == 3'h0) begin
          st_d.current_word_pointer = st_q.q2_next; // R10
        end
        if (st_q.pend == PEND_CYCLES - 3'h1) begin // R5
          st_d.q2st = aqscw_pkg::Q2_ACTIVE;
          st_d.pend = 3'h0;
        end else begin
          st_d.pend = st_q.pend + 3'h1;
        end
      end else begin
        st_d.pend = 3'h0;
      end
      if (st_q.q2st == aqscw_pkg::Q2_SUSP && st_d.q1st != aqscw_pkg::Q1_ACTIVE) begin
        st_d.q2st = aqscw_pkg::Q2_ACTIVE; // R3
      end
      if (!abort2) begin
        case (st_q.seq)
          aqscw_pkg::SEQ_IDLE: begin
            // Queue 1 always wins; a paused queue is never picked
            if (st_q.q1st == aqscw_pkg::Q1_ACTIVE) begin // R1
              st_d.cur_q = 1'b0;
              st_d.cur_ptr = st_q.q1_next;
              st_d.seq = aqscw_pkg::SEQ_FETCH;
            end else if (st_q.q2st == aqscw_pkg::Q2_ACTIVE) begin
              st_d.cur_q = 1'b1;
              st_d.cur_ptr = st_q.q2_next;
              st_d.seq = aqscw_pkg::SEQ_FETCH;
            end
          end
          aqscw_pkg::SEQ_FETCH: begin
            st_d.current_word_pointer = st_q.cur_ptr; // R9
            if (end_of_queue_code) begin // R11 R12 R13
              st_d.seq = aqscw_pkg::SEQ_IDLE;
              if (!st_q.cur_q) begin
                st_d.q1st = aqscw_pkg::Q1_IDLE;
                st_d.q1_next = `AQSCW_Q1_START;
                st_d.q1_wrap = 1'b0;
              end else begin
                st_d.q2st = aqscw_pkg::Q2_IDLE;
                st_d.q2_next = bq2;
                st_d.q2_wrap = 1'b0;
              end
            end else begin
              st_d.word = w;
              st_d.cnt = 8'h00;
              st_d.seq = aqscw_pkg::SEQ_CONV;
            end
          end
          aqscw_pkg::SEQ_CONV: begin
            if (st_q.conv_tick && st_q.cnt == total - 8'h01) begin
              st_d.res.valid = 1'b1;
              st_d.res.queue = st_q.cur_q;
              st_d.res.word = st_q.cur_ptr;
              st_d.res.channel_select = st_q.word.channel_select;
              st_d.res.sample_time_select = st_q.word.sample_time_select;
              st_d.res.amplifier_bypass = st_q.word.bypass
                || (st_q.word.channel_select >= `AQSCW_REF_FIRST
                    && st_q.word.channel_select <= `AQSCW_REF_LAST); // R22
              if (!st_q.cur_q) begin
                st_d.first_queue_pointer = st_q.cur_ptr; // R16
                st_d.q1_next = nxt;
                st_d.q1_wrap = st_q.cur_ptr == `AQSCW_LAST_WORD;
              end else begin
                st_d.second_queue_pointer = st_q.cur_ptr; // R18
                st_d.q2_next = nxt;
                st_d.q2_wrap = st_q.cur_ptr == `AQSCW_LAST_WORD;
              end
              if (st_q.word.pause && mode == aqscw_pkg::MODE_TRIG) begin // R19 R20
                st_d.seq = aqscw_pkg::SEQ_IDLE;
                if (!st_q.cur_q) begin
                  st_d.q1st = aqscw_pkg::Q1_PAUSED;
                end else begin
                  st_d.q2st = aqscw_pkg::Q2_PAUSED;
                end
              end else if (mode == aqscw_pkg::MODE_GATED && !gate) begin
                // Gate closed: scan stops and restarts from the queue start
                st_d.seq = aqscw_pkg::SEQ_IDLE;
                if (!st_q.cur_q) begin
                  st_d.q1st = aqscw_pkg::Q1_IDLE;
                  st_d.q1_next = start;
                  st_d.q1_wrap = 1'b0;
                end else begin
                  st_d.q2st = aqscw_pkg::Q2_IDLE;
                  st_d.q2_next = start;
                  st_d.q2_wrap = 1'b0;
                end
              end else begin
                st_d.cur_ptr = nxt;
                st_d.seq = aqscw_pkg::SEQ_FETCH;
              end
            end else if (st_q.conv_tick) begin
              st_d.cnt = st_q.cnt + 8'h01;
            end
          end
          default: st_d.seq = aqscw_pkg::SEQ_IDLE;
        endcase
      end
    end
    // Stop resets control and sequencing; the table keeps its contents
    if (stop_in) begin
      st_d.ctrl = `AQSCW_CTRL_RST;
      st_d.presc = `AQSCW_PRESC_RST;
      st_d.div_cnt = 8'h00;
      st_d.q1st = aqscw_pkg::Q1_IDLE; // R6
      st_d.q2st = aqscw_pkg::Q2_IDLE;
      st_d.seq = aqscw_pkg::SEQ_IDLE;
      st_d.current_word_pointer = `AQSCW_CWP_RST; // R14
      st_d.first_queue_pointer = `AQSCW_QPTR_RST; // R17
      st_d.second_queue_pointer = `AQSCW_QPTR_RST; // R18
      st_d.q1_next = `AQSCW_Q1_START;
      st_d.q2_next = 6'h00;
      st_d.q1_wrap = 1'b0;
      st_d.q2_wrap = 1'b0;
      st_d.pend = 3'h0;
      st_d.cnt = 8'h00;
      // A conversion cut by stop writes no result
      st_d.res.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '0;
      st_q.waitreq <= 1'b1;
      st_q.ctrl <= `AQSCW_CTRL_RST;
      st_q.current_word_pointer <= `AQSCW_CWP_RST;
      st_q.first_queue_pointer <= `AQSCW_QPTR_RST;
      st_q.second_queue_pointer <= `AQSCW_QPTR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata_out = st_q.rdata;
  assign avs_waitrequest_out = st_q.waitreq;
  assign result_out = st_q.res;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  property p_one_active;
    !(st_q.q1st == aqscw_pkg::Q1_ACTIVE && st_q.q2st == aqscw_pkg::Q2_ACTIVE)
    && !(st_q.seq != aqscw_pkg::SEQ_IDLE && !st_q.cur_q && st_q.q1st != aqscw_pkg::Q1_ACTIVE);
  endproperty
  a_one_active: assert property (p_one_active) else $error("two queues active"); // R1

  property p_abort;
    abort2 |=> st_q.q2st == aqscw_pkg::Q2_SUSP && st_q.seq == aqscw_pkg::SEQ_IDLE
               && st_q.q1st == aqscw_pkg::Q1_ACTIVE;
  endproperty
  a_abort: assert property (p_abort) else $error("queue 2 not suspended"); // R3

  property p_pending;
    (t2 && st_q.q1st == aqscw_pkg::Q1_ACTIVE && st_q.q2st == aqscw_pkg::Q2_IDLE)
    |=> st_q.q2st == aqscw_pkg::Q2_PEND;
  endproperty
  a_pending: assert property (p_pending) else $error("queue 2 not pending"); // R4

  property p_pend_delay;
    (st_q.q2st == aqscw_pkg::Q2_ACTIVE && $past(st_q.q2st) == aqscw_pkg::Q2_PEND)
    |-> $past(st_q.pend) == PEND_CYCLES - 3'h1 && $past(st_q.q1st) != aqscw_pkg::Q1_ACTIVE;
  endproperty
  a_pend_delay: assert property (p_pend_delay) else $error("pending promoted early"); // R5

  property p_cwp_early;
    (st_q.q2st == aqscw_pkg::Q2_PEND && st_q.q1st != aqscw_pkg::Q1_ACTIVE && st_q.pend == 3'h0
     && !t1 && !stop_in && !freeze_in && st_q.seq == aqscw_pkg::SEQ_IDLE)
    |=> st_q.current_word_pointer == $past(st_q.q2_next) && st_q.q2st == aqscw_pkg::Q2_PEND;
  endproperty
  a_cwp_early: assert property (p_cwp_early) else $error("pointer not moved ahead"); // R10

  property p_stop;
    stop_in |=> qs == 4'h0 && st_q.current_word_pointer == `AQSCW_CWP_RST
                && {st_q.first_queue_pointer, st_q.second_queue_pointer} == 12'hfff;
  endproperty
  a_stop: assert property (p_stop) else $error("stop reset incomplete"); // R6

  property p_freeze;
    (freeze_in && !stop_in) |=> $stable(qs) && $stable(st_q.current_word_pointer)
                                && $stable(st_q.first_queue_pointer);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved during freeze"); // R7

  property p_eoq_ptr;
    (st_q.seq == aqscw_pkg::SEQ_FETCH && end_of_queue_code && !abort2 && !stop_in && !freeze_in)
    |=> st_q.current_word_pointer == $past(st_q.cur_ptr) && st_q.seq == aqscw_pkg::SEQ_IDLE;
  endproperty
  a_eoq_ptr: assert property (p_eoq_ptr) else $error("end pointer wrong"); // R11

  property p_result_ptr;
    st_q.res.valid |-> (st_q.res.queue ? st_q.second_queue_pointer
                                       : st_q.first_queue_pointer) == st_q.res.word;
  endproperty
  a_result_ptr: assert property (p_result_ptr) else $error("queue pointer not updated"); // R16

  property p_pause;
    (st_q.seq == aqscw_pkg::SEQ_CONV && st_q.conv_tick && st_q.cnt == total - 8'h01
     && st_q.word.pause && mode == aqscw_pkg::MODE_TRIG && !st_q.cur_q && !stop_in && !freeze_in)
    |=> st_q.q1st == aqscw_pkg::Q1_PAUSED ##1 st_q.seq == aqscw_pkg::SEQ_IDLE;
  endproperty
  a_pause: assert property (p_pause) else $error("queue 1 did not pause"); // R19
endmodule
`default_nettype wire

//--- aqscw_regs.svh
// Register offsets, field positions, reset values and timing counts of the queue sequencer
`ifndef AQSCW_REGS_SVH
`define AQSCW_REGS_SVH
`define AQSCW_OFS_CTRL 12'h000
`define AQSCW_OFS_STAT 12'h004
`define AQSCW_OFS_PTRS 12'h008
`define AQSCW_OFS_PRESC 12'h00c
`define AQSCW_OFS_SWTRIG 12'h010
`define AQSCW_TBL_PAGE 4'h1
`define AQSCW_CTRL_RST 16'h0000
`define AQSCW_PRESC_RST 8'h00
`define AQSCW_PTRS_RST 16'h3f3f
`define AQSCW_QPTR_RST 6'h3f
`define AQSCW_CWP_RST 6'h00
`define AQSCW_Q1_START 6'h00
`define AQSCW_EOQ_CODE 6'h3f
`define AQSCW_LAST_WORD 6'h3f
`define AQSCW_REF_FIRST 6'h3c
`define AQSCW_REF_LAST 6'h3e
`define AQSCW_CTRL_Q1MODE 0
`define AQSCW_CTRL_Q2MODE 2
`define AQSCW_CTRL_Q1SRC 4
`define AQSCW_CTRL_Q2SRC 5
`define AQSCW_CTRL_BQ2 8
`define AQSCW_SWTRIG_Q1 0
`define AQSCW_SWTRIG_Q2 1
`define AQSCW_SAMPLE_BASE 8'h02
`define AQSCW_PEND_CYCLES 3'h2
`define AQSCW_CONV_CLKS 8'h0a
`endif

//--- aqscw_pkg.sv
// Types of the queue sequencer: modes, queue states, command word, result and block state
package aqscw_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_TRIG, MODE_SW, MODE_GATED} aqscw_mode_t;
  typedef enum logic [1:0] {Q1_IDLE, Q1_PAUSED, Q1_ACTIVE} aqscw_q1_t;
  typedef enum logic [2:0] {Q2_IDLE, Q2_PAUSED, Q2_ACTIVE, Q2_SUSP, Q2_PEND} aqscw_q2_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_CONV} aqscw_seq_t;
  typedef struct packed {
    logic [5:0] rsvd;
    logic pause;
    logic bypass;
    logic [1:0] sample_time_select;
    logic [5:0] channel_select;
  } aqscw_ccw_t;
  typedef struct packed {
    logic valid;
    logic queue;
    logic [5:0] word;
    logic [5:0] channel_select;
    logic [1:0] sample_time_select;
    logic amplifier_bypass;
  } aqscw_result_t;
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    logic [7:0] presc;
    logic [7:0] div_cnt;
    logic conv_tick;
    logic pin1;
    logic pin2;
    logic [63:0][15:0] words;
    aqscw_q1_t q1st;
    aqscw_q2_t q2st;
    aqscw_seq_t seq;
    logic cur_q;
    logic [5:0] cur_ptr;
    logic [5:0] current_word_pointer;
    logic [5:0] q1_next;
    logic q1_wrap;
    logic [5:0] q2_next;
    logic q2_wrap;
    logic [5:0] first_queue_pointer;
    logic [5:0] second_queue_pointer;
    logic [7:0] cnt;
    logic [2:0] pend;
    aqscw_ccw_t word;
    aqscw_result_t res;
  } aqscw_state_t;
endpackage

//--- aqscw_trig_model.sv
// Trigger source model: queue 1 pin edges and queue 2 timer ticks on request
`timescale 1ns/1ps
`default_nettype none
module aqscw_trig_model (
  // Clock
  input wire logic clk_sys_in,
  // Requests from the bench
  input wire logic fire1_in,
  input wire logic fire2_in,
  // Trigger lines towards the block
  output logic trig_q1_out,
  output var logic trig_q2_out,
  output var logic timer_tick_out
);
  logic [1:0] hold_q = 2'h0;
  initial trig_q2_out = 1'b0;
  initial timer_tick_out = 1'b0;
  // Pin stays high a few cycles so the edge is seen once, then drops for the next one
  always @(posedge clk_sys_in) begin
    if (fire1_in) begin
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
    timer_tick_out <= fire2_in;
    if (fire2_in) begin
      trig_q2_out <= ~trig_q2_out;
    end
  end
  assign trig_q1_out = (hold_q != 2'h0);
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the queue sequencer: registers, triggers, pause, priority, freeze, stop
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [11:0] addr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic stop = 1'b0;
  logic frz = 1'b0;
  logic fire1 = 1'b0;
  logic fire2 = 1'b0;
  logic t1;
  logic t2;
  logic tick;
  aqscw_pkg::aqscw_result_t res;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  int base;
  int n;
  logic [31:0] v;
  logic [5:0] c [4];
  always #5 clk_sys_in = ~clk_sys_in;
  aqscw_trig_model PART (.clk_sys_in(clk_sys_in), .fire1_in(fire1), .fire2_in(fire2),
    .trig_q1_out(t1), .trig_q2_out(t2), .timer_tick_out(tick));
  aqscw_core #(.CONV_CLKS(8'h01), .PEND_CYCLES(3'h2)) DUT (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .trig_q1_in(t1), .trig_q2_in(t2), .timer_tick_in(tick),
    .stop_in(stop), .freeze_in(frz), .result_out(res));
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles; far beyond that means a hang
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    do @(posedge clk_sys_in); while (waitreq !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic st(input logic [9:0] e);
    bus(1'b0, 12'h004, 32'h0);
    chk("status", {22'h0, e}, v);
  endtask
  task automatic fire(input logic q);
    @(posedge clk_sys_in);
    fire1 <= ~q;
    fire2 <= q;
    @(posedge clk_sys_in);
    fire1 <= 1'b0;
    fire2 <= 1'b0;
    t0 = cyc;
  endtask
  task automatic wres(input logic q, input logic [5:0] w, input logic [5:0] ch,
                      input logic [1:0] s, input logic b);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (res.valid !== 1'b1 && n < 3000);
    chk("result", {15'h0, 1'b1, q, w, ch, s, b}, {15'h0, res});
  endtask
  function automatic logic [31:0] conversion_command_word_table(logic p, logic b, logic [1:0] s, logic [5:0] ch);
    return {22'h0, p, b, s, ch};
  endfunction
  initial begin
    base = $urandom(18);
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    bus(1'b0, 12'h008, 32'h0);
    chk("pointers", 32'h3f3f, v);
    st(10'h000);
    bus(1'b1, 12'h008, 32'h0);
    bus(1'b1, 12'h004, 32'h3ff);
    bus(1'b0, 12'h008, 32'h0);
    chk("pointers", 32'h3f3f, v);
    st(10'h000);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, v);
    for (int i = 0; i < 8; i++) begin
      t0 = 12'h100 + 4 * (2 + $urandom() % 60);
      base = $urandom() & 32'h3ff;
      bus(1'b1, t0[11:0], base);
      bus(1'b0, t0[11:0], 32'h0);
      chk("table", base, v);
    end
    $display("test registers done");
    // Queue 1 ends on reading the queue 2 start word
    bus(1'b1, 12'h000, 32'h0101);
    for (int s = 0; s < 4; s++) begin
      c[0] = 6'($urandom() % 60);
      bus(1'b1, 12'h100, conversion_command_word_table(1'b0, 1'b0, s[1:0], c[0]));
      fire(1'b0);
      wres(1'b0, 6'h00, c[0], s[1:0], 1'b0);
      if (s == 0) begin
        base = cyc - t0;
      end else begin
        chk("sample span", (2 << s) - 2, cyc - t0 - base);
      end
      repeat (4) @(posedge clk_sys_in);
    end
    st(10'h001);
    bus(1'b0, 12'h008, 32'h0);
    chk("pointers", 32'h003f, v);
    $display("test sample time done");
    for (int i = 1; i < 4; i++) c[i] = 6'($urandom() % 60);
    bus(1'b1, 12'h000, 32'h3e25);
    bus(1'b1, 12'h100, conversion_command_word_table(1'b1, 1'b0, 2'h0, 6'h3d));
    bus(1'b1, 12'h104, conversion_command_word_table(1'b0, 1'b0, 2'h3, c[1]));
    bus(1'b1, 12'h108, conversion_command_word_table(1'b0, 1'b0, 2'h0, 6'h3f));
    bus(1'b1, 12'h1f8, conversion_command_word_table(1'b0, 1'b1, 2'h3, c[2]));
    bus(1'b1, 12'h1fc, conversion_command_word_table(1'b0, 1'b0, 2'h3, c[3]));
    fire(1'b0);
    wres(1'b0, 6'h00, 6'h3d, 2'h0, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    st(10'h100);
    fire(1'b1);
    repeat (4) @(posedge clk_sys_in);
    st(10'h1be);
    fire(1'b0);
    repeat (4) @(posedge clk_sys_in);
    st(10'h281);
    wres(1'b0, 6'h01, c[1], 2'h3, 1'b0);
    wres(1'b1, 6'h3e, c[2], 2'h3, 1'b1);
    wres(1'b1, 6'h3f, c[3], 2'h3, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    st(10'h000);
    bus(1'b0, 12'h008, 32'h0);
    chk("pointers", 32'h013f, v);
    $display("test pause and suspend done");
    bus(1'b1, 12'h100, conversion_command_word_table(1'b1, 1'b0, 2'h3, 6'h3d));
    fire(1'b0);
    fire(1'b1);
    st(10'h2c0);
    wres(1'b0, 6'h00, 6'h3d, 2'h3, 1'b1);
    wres(1'b1, 6'h3e, c[2], 2'h3, 1'b1);
    wres(1'b1, 6'h3f, c[3], 2'h3, 1'b0);
    $display("test pending done");
    fire(1'b0);
    repeat (4) @(posedge clk_sys_in);
    frz <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clk_sys_in);
      if (res.valid !== 1'b0) n++;
    end
    chk("frozen results", 32'h0, n);
    st(10'h201);
    @(posedge clk_sys_in);
    frz <= 1'b0;
    wres(1'b0, 6'h01, c[1], 2'h3, 1'b0);
    $display("test freeze done");
    // Software mode: pause flag is ignored, scan runs on to the end code
    bus(1'b1, 12'h000, 32'h3e26);
    bus(1'b1, 12'h010, 32'h1);
    wres(1'b0, 6'h00, 6'h3d, 2'h3, 1'b1);
    wres(1'b0, 6'h01, c[1], 2'h3, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    st(10'h002);
    // Gated mode: short gate ends the scan after one word, no pause
    bus(1'b1, 12'h000, 32'h3e27);
    fire(1'b0);
    wres(1'b0, 6'h00, 6'h3d, 2'h3, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    st(10'h000);
    $display("test pause modes done");
    @(posedge clk_sys_in);
    stop <= 1'b1;
    bus(1'b1, 12'h000, 32'h0101);
    st(10'h000);
    bus(1'b0, 12'h008, 32'h0);
    chk("pointers", 32'h3f3f, v);
    bus(1'b0, 12'h000, 32'h0);
    chk("control", 32'h0, v);
    stop <= 1'b0;
    $display("test stop done");
    stop_test();
  end
endmodule
`default_nettype wire
